// [bench/cct_dsp_model.sv]
// Processor serial port model: sends primary and secondary words, collects returned words
`timescale 1ns/10ps
module cct_dsp_model
	import cct_pkg::*;
(
	// Clock and serial port
	input  wire logic              sys_clk,
	input  wire logic              shift_clk,
	input  wire logic              tx_frame_sync,
	input  wire logic              rx_frame_sync,
	input  wire logic              serial_data_from_codec,
	output logic                   serial_data_to_codec,
	// Words to send and last word received
	input  wire logic [WORD_W-1:0] prim_word,
	input  wire logic [WORD_W-1:0] sec_word,
	output logic      [WORD_W-1:0] rx_word
);
	logic              hi_q   = 1'b0;
	logic              sec_q  = 1'b0;
	logic              junk_q = 1'b0;
	logic [3:0]        idx_q  = 4'hF;
	logic [WORD_W-1:0] sh_q;
	wire               tick = shift_clk & hi_q;

	// ==================================================
	// Tick finder, bit index and receive shifter
	always @(posedge sys_clk) begin
		hi_q   <= shift_clk & ~hi_q;
		junk_q <= ~junk_q;
		if (tick && !tx_frame_sync) begin
			idx_q <= idx_q - 4'h1;
			if (idx_q == 4'h0) sec_q <= !sec_q && prim_word[1:0] == 2'b11;
		end else if (tx_frame_sync) begin
			idx_q <= 4'hF;
		end
		if (tick && !rx_frame_sync) sh_q <= {sh_q[WORD_W-2:0], serial_data_from_codec};
		if (rx_frame_sync) rx_word <= sh_q;
	end

	// Current bit inside a frame, a toggling pattern outside
	assign serial_data_to_codec = tx_frame_sync ? junk_q : (sec_q ? sec_word[idx_q] : prim_word[idx_q]);
endmodule : cct_dsp_model

// [bench/cct_timing_tb.sv]
// Self-checking bench for the codec conversion timing block
`timescale 1ns/10ps
module cct_timing_tb
	import cct_pkg::*;
;
	// ==================================================
	// Stimulus and observed signals
	logic              sys_clk = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic              ce = 1'b1;
	logic [ADR_W-1:0]  wb_adr_i = 8'h00;
	logic [BUS_W-1:0]  wb_dat_i = 32'h0000_0000, wb_dat_o, rdat;
	logic [DATA_W-1:0] adc_sample = 14'h2A5C, dac_word;
	logic [WORD_W-1:0] prim = 16'h0000, sec = 16'h02E7, rxw;
	logic              serial_data_to_codec, shift_clk, tx_frame_sync, rx_frame_sync, serial_data_from_codec;
	logic              da_conv_strobe, ad_conv_strobe, hp_filter_clock;
	logic              tx_switched_cap_filter_clock, rx_switched_cap_filter_clock;
	int                miscompares = 0, num_checks = 0, ticks = 0, n, m;
	logic [31:0]       tab [7] = '{32'h0000_0009, 32'h0000_0001, 32'h0000_0024, 32'h0000_0009,
		32'h0000_0001, 32'h0000_0024, 32'h0000_02E4};

	// Clock of 8 ns
	always #4 sys_clk = ~sys_clk;

	// ==================================================
	// Design and processor model
	cct_timing u_dut (.sys_clk, .srst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF),
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .serial_data_to_codec, .shift_clk, .tx_frame_sync, .rx_frame_sync,
		.serial_data_from_codec, .adc_sample, .dac_word, .da_conv_strobe, .ad_conv_strobe,
		.tx_switched_cap_filter_clock, .rx_switched_cap_filter_clock, .hp_filter_clock);
	cct_dsp_model u_dsp (.sys_clk, .shift_clk, .tx_frame_sync, .rx_frame_sync, .serial_data_from_codec,
		.serial_data_to_codec, .prim_word(prim), .sec_word(sec), .rx_word(rxw));

	// ==================================================
	// Shared tasks
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report

	task cyc;
		@(posedge sys_clk);
		#1;
		ticks++;
		if (ticks > 90000) begin
			miscompares++;
			final_report;
		end
	endtask : cyc

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Classic single Wishbone cycle, released at the acknowledging edge
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int k;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (k >= 50) begin
			miscompares++;
			final_report;
		end
	endtask : wb

	function logic sig(input int w);
		case (w)
			0: sig = shift_clk;
			1: sig = da_conv_strobe;
			2: sig = ad_conv_strobe;
			3: sig = hp_filter_clock;
			4: sig = tx_switched_cap_filter_clock;
			5: sig = rx_switched_cap_filter_clock;
			default: sig = tx_frame_sync;
		endcase
	endfunction : sig

	task wait_for(input int w, input logic lvl);
		do cyc; while (sig(w) !== lvl);
	endtask : wait_for

	task dur(input int w, input logic lvl, output int k);
		k = 0;
		while (sig(w) === lvl && k < 5000) begin
			cyc;
			k++;
		end
	endtask : dur

	// Clock enable low for a while: shift clock must not move
	task ce_case;
		logic s;
		@(posedge sys_clk);
		ce <= 1'b0;
		cyc;
		s = shift_clk;
		repeat (8) begin
			cyc;
			chk("ce_freeze", 32'(s), 32'(shift_clk));
		end
		@(posedge sys_clk);
		ce <= 1'b1;
	endtask : ce_case

	// Cycles from one rise of a signal to the next
	task per(input int w, output int k);
		int a;
		wait_for(w, 1'b0);
		wait_for(w, 1'b1);
		dur(w, 1'b1, a);
		dur(w, 1'b0, k);
		k = k + a;
	endtask : per

	// One primary word with the given low bits, then the two following periods
	task prim_case(input logic [1:0] c, input int exp);
		wait_for(6, 1'b1);
		prim = {14'h270C, c};
		wait_for(6, 1'b0);
		wait_for(6, 1'b1);
		prim = {14'h270C, 2'b00};
		if (c == 2'b11) begin
			dur(6, 1'b1, n);
			chk("gap", 16, n);
			n = 0;
			m = 0;
			while (tx_frame_sync === 1'b0 && n < 200) begin
				m = m | !rx_frame_sync;
				cyc;
				n++;
			end
			chk("sec_len", 64, n);
			chk("sec_rx", 0, m);
			wb(1'b0, ADR_WORDS, 32'h0000_0000, rdat);
			chk("words", {sec, 14'h270C, c}, rdat);
		end
		per(1, n);
		chk("da_trim", exp, n);
		per(1, n);
		chk("da_next", 648, n);
		chk("dac", 32'(14'h270C), 32'(dac_word));
	endtask : prim_case

	// ==================================================
	// Main sequence
	initial begin
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			wb(1'b0, 8'(4 * i), 32'h0000_0000, rdat);
			chk("reg", tab[i], rdat);
		end
		wb(1'b1, 8'h20, 32'hFFFF_FFFF, rdat);
		wb(1'b0, 8'h20, 32'h0000_0000, rdat);
		chk("unmapped", 32'h0000_0000, rdat);
		ce_case;
		per(0, n);
		chk("shift", 4, n);
		per(4, n);
		chk("tx_scf", 18, n);
		per(1, n);
		chk("da", 2 * 9 * 36, n);
		prim_case(2'b00, 648);
		prim_case(2'b01, 649);
		prim_case(2'b10, 647);
		prim_case(2'b11, 648);
		chk("rx_word", {adc_sample, 2'b00}, rxw);
		wb(1'b1, ADR_RX_BASE, 32'h0000_0004, rdat);
		wb(1'b1, ADR_RX_DIV, 32'h0000_0003, rdat);
		per(2, n);
		chk("ad_sync", 648, n);
		wb(1'b1, ADR_CTRL, 32'h0000_02C4, rdat);
		per(2, n);
		chk("ad_async", 24, n);
		per(3, n);
		chk("hp", 24, n);
		per(5, n);
		chk("rx_scf", 8, n);
		wb(1'b1, ADR_TX_TRIM, 32'h0000_0008, rdat);
		prim_case(2'b10, 648);
		final_report;
	end
endmodule : cct_timing_tb

// [logic/cct_div_if.sv]
// Carrier between the top and one counter pair
`timescale 1ns/10ps
interface cct_div_if;
	import cct_pkg::*;

	logic [BASE_W-1:0] base;
	logic [TRIM_W-1:0] trim;
	logic [DIV_W-1:0]  divisor;
	cct_sel_t          sel;
	logic              run;
	logic              take;
	logic              switched_cap_filter_clock;
	logic              conv;

	modport ctl (output base, trim, divisor, sel, run, input take, switched_cap_filter_clock, conv);
	modport div (input base, trim, divisor, sel, run, output take, switched_cap_filter_clock, conv);

endinterface : cct_div_if

// [logic/cct_divider.sv]
// Reloadable counter pair: filter clock and conversion strobe
`timescale 1ns/10ps
module cct_divider
	import cct_pkg::*;
(
	// Clock, reset and freeze
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic ce,
	// Load values and results
	cct_div_if.div    ifc
);

	// ==================================================
	// State
	logic [CNTA_W-1:0] cnt_a_r, cnt_a_nxt;
	logic [DIV_W-1:0]  cnt_b_r, cnt_b_nxt;
	logic              half_r,  half_nxt;
	logic              scf_r,   scf_nxt;
	logic              conv_r,  conv_nxt;
	logic              a_end;
	logic              b_end;
	logic [CNTA_W-1:0] base_x;

	// Counter A load for the first segment of a period
	function automatic logic [CNTA_W-1:0] trim_load(input logic [BASE_W-1:0] base,
		input logic [TRIM_W-1:0] trim, input cct_sel_t sel);
		logic signed [SUM_W-1:0] b;
		logic signed [SUM_W-1:0] t;
		logic signed [SUM_W-1:0] s;
		b = signed'({{(SUM_W - BASE_W){1'b0}}, base});
		t = signed'({trim[TRIM_W-1], trim});
		case (sel)
			CCT_SEL_PLUS:  s = b + t;
			CCT_SEL_MINUS: s = b - t;
			default:       s = b;
		endcase
		if (s == SUM_ZERO || s == SUM_ONE) begin
			s = b;
		end else if (s < SUM_ZERO) begin
			s = s + MOD_ADJ; // Keep the load positive
		end
		return s[CNTA_W-1:0];
	endfunction : trim_load

	assign base_x = {{(CNTA_W - BASE_W){1'b0}}, ifc.base};
	assign a_end  = (cnt_a_r <= CNTA_ONE);
	assign b_end  = (cnt_b_r <= DIV_ONE);
	// Reload moment, seen by the top to retire the trim choice
	assign ifc.take = ce && ifc.run && a_end && half_r && b_end;
	assign ifc.switched_cap_filter_clock  = scf_r;
	assign ifc.conv = conv_r;

	// Next state: A halves the filter clock, B counts filter periods
	always_comb begin
		cnt_a_nxt = cnt_a_r;
		cnt_b_nxt = cnt_b_r;
		half_nxt  = half_r;
		scf_nxt   = scf_r;
		conv_nxt  = 1'b0;
		if (!ifc.run) begin
			cnt_a_nxt = base_x;
			cnt_b_nxt = ifc.divisor;
			half_nxt  = 1'b0;
			scf_nxt   = 1'b0;
		end else if (a_end) begin
			scf_nxt  = ~scf_r;
			half_nxt = ~half_r;
			cnt_a_nxt = base_x;
			if (half_r) begin
				if (b_end) begin
					conv_nxt  = 1'b1;
					cnt_b_nxt = ifc.divisor;
					cnt_a_nxt = trim_load(ifc.base, ifc.trim, ifc.sel);
				end else begin
					cnt_b_nxt = cnt_b_r - DIV_ONE;
				end
			end
		end else begin
			cnt_a_nxt = cnt_a_r - CNTA_ONE;
		end
	end

	// Registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cnt_a_r <= CNTA_RST;
			cnt_b_r <= DIV_RST;
			half_r  <= 1'b0;
			scf_r   <= 1'b0;
			conv_r  <= 1'b0;
		end else if (ce) begin
			cnt_a_r <= cnt_a_nxt;
			cnt_b_r <= cnt_b_nxt;
			half_r  <= half_nxt;
			scf_r   <= scf_nxt;
			conv_r  <= conv_nxt;
		end
	end

	// ==================================================
	// Checks
	b_reload_a: assert property (@(posedge sys_clk) disable iff (srst)
		(conv_r && $past(ce)) |-> cnt_b_r == $past(ifc.divisor))
		else $error("counter B not reloaded from divisor");
	a_base_a: assert property (@(posedge sys_clk) disable iff (srst)
		(conv_r && $past(ce) && $past(ifc.sel) == CCT_SEL_BASE) |-> cnt_a_r == $past(base_x))
		else $error("counter A not reloaded from base");
	scf_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
		($past(ce) && $past(ifc.run) && $past(cnt_a_r) > CNTA_ONE) |-> scf_r == $past(scf_r))
		else $error("filter clock toggled before counter A ran out");

endmodule : cct_divider

// [logic/cct_pkg.sv]
// Shared constants, register map and types for the codec conversion timing block
package cct_pkg;

	// ==================================================
	// Widths
	localparam int BASE_W = 5;
	localparam int TRIM_W = 7;
	localparam int DIV_W  = 6;
	localparam int CNTA_W = 7;
	localparam int SUM_W  = 8;
	localparam int WORD_W = 16;
	localparam int DATA_W = 14;
	localparam int LSB_W  = 2;
	localparam int CTRL_W = 10;
	localparam int BYTE_W = 8;
	localparam int ADR_W  = 8;
	localparam int BUS_W  = 32;

	// ==================================================
	// Reset values
	localparam logic [BASE_W-1:0] BASE_RST = 5'h09;
	localparam logic [CNTA_W-1:0] CNTA_RST = 7'h09;
	localparam logic [TRIM_W-1:0] TRIM_RST = 7'h01;
	localparam logic [DIV_W-1:0]  DIV_RST  = 6'h24;
	localparam logic [CTRL_W-1:0] CTRL_RST = 10'h2E4;
	localparam int                CTRL_SYNC_BIT = 5;

	// ==================================================
	// Register byte addresses, one word each
	localparam logic [ADR_W-1:0] ADR_TX_BASE = 8'h00;
	localparam logic [ADR_W-1:0] ADR_TX_TRIM = 8'h04;
	localparam logic [ADR_W-1:0] ADR_TX_DIV  = 8'h08;
	localparam logic [ADR_W-1:0] ADR_RX_BASE = 8'h0C;
	localparam logic [ADR_W-1:0] ADR_RX_TRIM = 8'h10;
	localparam logic [ADR_W-1:0] ADR_RX_DIV  = 8'h14;
	localparam logic [ADR_W-1:0] ADR_CTRL    = 8'h18;
	localparam logic [ADR_W-1:0] ADR_WORDS   = 8'h1C;

	// ==================================================
	// Timing
	localparam int                SHIFT_DIV    = 4;
	localparam int                GAP_SHIFTS   = 4;
	localparam logic [1:0]        PRE_ONE      = 2'h1;
	localparam logic [1:0]        PRE_LAST     = 2'(SHIFT_DIV - 1);
	localparam logic [1:0]        PRE_HALF     = 2'(SHIFT_DIV / 2);
	localparam logic [4:0]        BIT_ONE      = 5'h01;
	localparam logic [4:0]        BIT_ZERO     = 5'h00;
	localparam logic [4:0]        BIT_LAST     = 5'(WORD_W - 1);
	localparam logic [4:0]        GAP_LAST     = 5'(GAP_SHIFTS - 1);
	localparam logic [4:0]        GAP_CYC_LAST = 5'(GAP_SHIFTS * SHIFT_DIV - 1);
	localparam logic [CNTA_W-1:0] CNTA_ONE     = 7'h01;
	localparam logic [DIV_W-1:0]  DIV_ONE      = 6'h01;
	localparam logic signed [SUM_W-1:0] SUM_ZERO = 8'sh00;
	localparam logic signed [SUM_W-1:0] SUM_ONE  = 8'sh01;
	localparam logic signed [SUM_W-1:0] MOD_ADJ  = 8'sh40;

	// ==================================================
	// Types
	typedef enum logic [1:0] {
		CCT_SEL_BASE  = 2'b00,
		CCT_SEL_PLUS  = 2'b01,
		CCT_SEL_MINUS = 2'b10,
		CCT_SEL_SEC   = 2'b11
	} cct_sel_t;

	typedef enum logic [1:0] {
		SP_IDLE = 2'b00,
		SP_PRIM = 2'b01,
		SP_GAP  = 2'b10,
		SP_SEC  = 2'b11
	} cct_sp_t;

endpackage : cct_pkg

// [logic/cct_timing.sv]
// Codec conversion timing: dividers, serial framing and primary word decode
//
// Behaviour
// - Shift clock is the master clock divided by four.
// - Transmit pair: filter clock is master over 2A, conversion over B.
// - Receive pair divides the same way for the A/D side.
// - High-pass filter clock runs at the A/D conversion rate.
// - Each pair reloads counter A every filter half period and counter B once per conversion period.
// - Counter B reloads from its rate divisor.
// - Transmit counter A loads base, base minus trim or base plus trim.
// - Receive counter A offers the same three load choices.
// - Synchronous mode takes all timing from the transmit pair.
// - Sixteen-bit words, MSB first; bits 15 to 2 carry converter data.
// - Low bits 00 load plain bases and divisors.
// - Low bits 01 load base plus trim for the next period.
// - Low bits 10 load base minus trim for the next period.
// - Low bits 11 load normally, then a secondary transfer after four shifts.
// - Transmit frame sync stays high four shifts, then falls for the secondary.
// - Secondary uses primary timing, slotted between primaries.
// - Synchronous mode gives no receive frame sync during a secondary.
// - Control bit 5 selects asynchronous (0) or synchronous (1) operation.
// - Reset gives bases 9, trims 1, divisors 24 hex.
// - Base plus or minus trim of 0 or 1 loads the plain base.
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
module cct_timing
	import cct_pkg::*;
(
	// Clock, reset and freeze
	input  wire logic              sys_clk,
	input  wire logic              srst,
	input  wire logic              ce,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [BUS_W-1:0]  wb_dat_i,
	output logic      [BUS_W-1:0]  wb_dat_o,
	output logic                   wb_ack_o,
	// Serial port to the processor
	input  wire logic              serial_data_to_codec,
	output logic                   shift_clk,
	output logic                   tx_frame_sync,
	output logic                   rx_frame_sync,
	output logic                   serial_data_from_codec,
	// Converter and filter side
	input  wire logic [DATA_W-1:0] adc_sample,
	output logic      [DATA_W-1:0] dac_word,
	output logic                   da_conv_strobe,
	output logic                   ad_conv_strobe,
	output logic                   tx_switched_cap_filter_clock,
	output logic                   rx_switched_cap_filter_clock,
	output logic                   hp_filter_clock
);

	// ==================================================
	// Register file
	logic [BASE_W-1:0] txb_r,  txb_nxt,  rxb_r, rxb_nxt;
	logic [TRIM_W-1:0] txt_r,  txt_nxt,  rxt_r, rxt_nxt;
	logic [DIV_W-1:0]  txd_r,  txd_nxt,  rxd_r, rxd_nxt;
	logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic              ack_r,  ack_nxt;
	logic [BUS_W-1:0]  rdat_r, rdat_nxt;
	logic              wr;
	logic              sync;

	// Serial and decode state
	logic [1:0]        pre_r, pre_nxt;
	logic              shift_r, shift_nxt;
	cct_sp_t           sp_r, sp_nxt;
	logic [4:0]        bit_r, bit_nxt;
	logic [WORD_W-1:0] sh_r, sh_nxt;
	logic              txfs_r, txfs_nxt;
	logic              tx_pend_r, tx_pend_nxt;
	logic [WORD_W-1:0] prim_r, prim_nxt;
	logic [WORD_W-1:0] sec_r, sec_nxt;
	logic [DATA_W-1:0] dac_r, dac_nxt;
	cct_sel_t          tx_sel_r, tx_sel_nxt;
	cct_sel_t          rx_sel_r, rx_sel_nxt;
	cct_sel_t          dec_sel;
	logic              rx_busy_r, rx_busy_nxt;
	logic [4:0]        rx_bit_r, rx_bit_nxt;
	logic [WORD_W-1:0] rx_sh_r, rx_sh_nxt;
	logic              rxfs_r, rxfs_nxt;
	logic              rx_pend_r, rx_pend_nxt;
	logic              sdo_r, sdo_nxt;
	logic              tick;
	logic              tx_start;
	logic              prim_end;
	logic              rx_go;
	logic [WORD_W-1:0] word;

	// Converter side outputs
	logic              da_r, ad_r, tscf_r, rscf_r, hp_r;
	logic              ad_c;

	// Counter pairs
	cct_div_if tx_if ();
	cct_div_if rx_if ();

	assign sync = ctrl_r[CTRL_SYNC_BIT];
	assign wr   = ack_nxt && wb_we_i;

	// ==================================================
	// Wishbone decode; one-cycle answer, unmapped reads zero
	always_comb begin
		txb_nxt  = txb_r;
		txt_nxt  = txt_r;
		txd_nxt  = txd_r;
		rxb_nxt  = rxb_r;
		rxt_nxt  = rxt_r;
		rxd_nxt  = rxd_r;
		ctrl_nxt = ctrl_r;
		ack_nxt  = wb_cyc_i && wb_stb_i && !ack_r;
		rdat_nxt = rdat_r;
		if (ack_nxt) begin
			rdat_nxt = '0;
			if (wb_adr_i == ADR_TX_BASE) begin
				rdat_nxt[BASE_W-1:0] = txb_r;
				if (wr && wb_sel_i[0]) txb_nxt = wb_dat_i[BASE_W-1:0];
			end else if (wb_adr_i == ADR_TX_TRIM) begin
				rdat_nxt[TRIM_W-1:0] = txt_r;
				if (wr && wb_sel_i[0]) txt_nxt = wb_dat_i[TRIM_W-1:0];
			end else if (wb_adr_i == ADR_TX_DIV) begin
				rdat_nxt[DIV_W-1:0] = txd_r;
				if (wr && wb_sel_i[0]) txd_nxt = wb_dat_i[DIV_W-1:0];
			end else if (wb_adr_i == ADR_RX_BASE) begin
				rdat_nxt[BASE_W-1:0] = rxb_r;
				if (wr && wb_sel_i[0]) rxb_nxt = wb_dat_i[BASE_W-1:0];
			end else if (wb_adr_i == ADR_RX_TRIM) begin
				rdat_nxt[TRIM_W-1:0] = rxt_r;
				if (wr && wb_sel_i[0]) rxt_nxt = wb_dat_i[TRIM_W-1:0];
			end else if (wb_adr_i == ADR_RX_DIV) begin
				rdat_nxt[DIV_W-1:0] = rxd_r;
				if (wr && wb_sel_i[0]) rxd_nxt = wb_dat_i[DIV_W-1:0];
			end else if (wb_adr_i == ADR_CTRL) begin
				rdat_nxt[CTRL_W-1:0] = ctrl_r;
				if (wr && wb_sel_i[0]) ctrl_nxt[BYTE_W-1:0] = wb_dat_i[BYTE_W-1:0];
				if (wr && wb_sel_i[1]) ctrl_nxt[CTRL_W-1:BYTE_W] = wb_dat_i[CTRL_W-1:BYTE_W];
			end else if (wb_adr_i == ADR_WORDS) begin
				rdat_nxt = {sec_r, prim_r};
			end
		end
	end

	// Register file flops
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			txb_r  <= BASE_RST;
			txt_r  <= TRIM_RST;
			txd_r  <= DIV_RST;
			rxb_r  <= BASE_RST;
			rxt_r  <= TRIM_RST;
			rxd_r  <= DIV_RST;
			ctrl_r <= CTRL_RST;
			ack_r  <= 1'b0;
			rdat_r <= '0;
		end else if (ce) begin
			txb_r  <= txb_nxt;
			txt_r  <= txt_nxt;
			txd_r  <= txd_nxt;
			rxb_r  <= rxb_nxt;
			rxt_r  <= rxt_nxt;
			rxd_r  <= rxd_nxt;
			ctrl_r <= ctrl_nxt;
			ack_r  <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// ==================================================
	// Counter pairs; receive pair idles in synchronous mode
	assign tx_if.base    = txb_r;
	assign tx_if.trim    = txt_r;
	assign tx_if.divisor = txd_r;
	assign tx_if.sel     = tx_sel_r;
	assign tx_if.run     = 1'b1;
	assign rx_if.base    = rxb_r;
	assign rx_if.trim    = rxt_r;
	assign rx_if.divisor = rxd_r;
	assign rx_if.sel     = rx_sel_r;
	assign rx_if.run     = !sync;

	cct_divider u_tx_div (
		.sys_clk (sys_clk),
		.srst    (srst),
		.ce      (ce),
		.ifc     (tx_if.div)
	);

	cct_divider u_rx_div (
		.sys_clk (sys_clk),
		.srst    (srst),
		.ce      (ce),
		.ifc     (rx_if.div)
	);

	assign ad_c = sync ? tx_if.conv : rx_if.conv;

	// ==================================================
	// Shift clock, transmit framing and word decode
	assign tick    = (pre_r == PRE_LAST);
	assign word    = {sh_r[WORD_W-2:0], serial_data_to_codec};
	assign dec_sel = (word[LSB_W-1:0] == CCT_SEL_SEC) ? CCT_SEL_BASE : cct_sel_t'(word[LSB_W-1:0]);

	always_comb begin
		pre_nxt     = pre_r + PRE_ONE;
		shift_nxt   = (pre_nxt >= PRE_HALF);
		sp_nxt      = sp_r;
		bit_nxt     = bit_r;
		sh_nxt      = sh_r;
		txfs_nxt    = txfs_r;
		tx_pend_nxt = tx_pend_r;
		prim_nxt    = prim_r;
		sec_nxt     = sec_r;
		dac_nxt     = dac_r;
		tx_sel_nxt  = tx_sel_r;
		rx_sel_nxt  = rx_sel_r;
		tx_start    = 1'b0;
		prim_end    = 1'b0;
		if (tick) begin
			case (sp_r)
				SP_IDLE: if (tx_pend_r) begin
					tx_start    = 1'b1;
					tx_pend_nxt = 1'b0;
					sp_nxt      = SP_PRIM;
					txfs_nxt    = 1'b0;
					bit_nxt     = BIT_LAST;
				end
				SP_PRIM, SP_SEC: begin
					sh_nxt = word;
					if (bit_r == BIT_ZERO) begin
						txfs_nxt = 1'b1;
						sp_nxt   = SP_IDLE;
						if (sp_r == SP_SEC) begin
							sec_nxt = word;
						end else begin
							prim_end = 1'b1;
							prim_nxt = word;
							dac_nxt  = word[WORD_W-1:LSB_W];
							if (word[LSB_W-1:0] == CCT_SEL_SEC) begin
								sp_nxt  = SP_GAP;
								bit_nxt = GAP_LAST;
							end
						end
					end else begin
						bit_nxt = bit_r - BIT_ONE;
					end
				end
				SP_GAP: if (bit_r == BIT_ZERO) begin
					sp_nxt   = SP_SEC;
					txfs_nxt = 1'b0;
					bit_nxt  = BIT_LAST;
				end else begin
					bit_nxt = bit_r - BIT_ONE;
				end
			endcase
		end
		// Trim choice retires at its reload; a fresh decode wins
		if (tx_if.take) tx_sel_nxt = CCT_SEL_BASE;
		if (rx_if.take || (sync && tx_if.take)) rx_sel_nxt = CCT_SEL_BASE;
		if (prim_end) begin
			tx_sel_nxt = dec_sel;
			rx_sel_nxt = dec_sel;
		end
		if (tx_if.conv) tx_pend_nxt = 1'b1;
	end

	// ==================================================
	// Receive framing toward the processor
	assign rx_go = sync ? tx_start : (tick && !rx_busy_r && rx_pend_r);

	always_comb begin
		rx_busy_nxt = rx_busy_r;
		rx_bit_nxt  = rx_bit_r;
		rx_sh_nxt   = rx_sh_r;
		rxfs_nxt    = rxfs_r;
		rx_pend_nxt = rx_pend_r;
		sdo_nxt     = sdo_r;
		if (rx_go) begin
			rx_busy_nxt = 1'b1;
			rxfs_nxt    = 1'b0;
			rx_bit_nxt  = BIT_LAST;
			rx_sh_nxt   = {adc_sample, {LSB_W{1'b0}}};
			sdo_nxt     = adc_sample[DATA_W-1];
			rx_pend_nxt = 1'b0;
		end else if (tick && rx_busy_r) begin
			if (rx_bit_r == BIT_ZERO) begin
				rx_busy_nxt = 1'b0;
				rxfs_nxt    = 1'b1;
			end else begin
				rx_bit_nxt = rx_bit_r - BIT_ONE;
				rx_sh_nxt  = {rx_sh_r[WORD_W-2:0], 1'b0};
				sdo_nxt    = rx_sh_r[WORD_W-2];
			end
		end
		if (ad_c) rx_pend_nxt = 1'b1;
	end

	// Serial flops
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pre_r     <= '0;
			shift_r   <= 1'b0;
			sp_r      <= SP_IDLE;
			bit_r     <= BIT_ZERO;
			sh_r      <= '0;
			txfs_r    <= 1'b1;
			tx_pend_r <= 1'b0;
			prim_r    <= '0;
			sec_r     <= '0;
			dac_r     <= '0;
			tx_sel_r  <= CCT_SEL_BASE;
			rx_sel_r  <= CCT_SEL_BASE;
			rx_busy_r <= 1'b0;
			rx_bit_r  <= BIT_ZERO;
			rx_sh_r   <= '0;
			rxfs_r    <= 1'b1;
			rx_pend_r <= 1'b0;
			sdo_r     <= 1'b0;
		end else if (ce) begin
			pre_r     <= pre_nxt;
			shift_r   <= shift_nxt;
			sp_r      <= sp_nxt;
			bit_r     <= bit_nxt;
			sh_r      <= sh_nxt;
			txfs_r    <= txfs_nxt;
			tx_pend_r <= tx_pend_nxt;
			prim_r    <= prim_nxt;
			sec_r     <= sec_nxt;
			dac_r     <= dac_nxt;
			tx_sel_r  <= tx_sel_nxt;
			rx_sel_r  <= rx_sel_nxt;
			rx_busy_r <= rx_busy_nxt;
			rx_bit_r  <= rx_bit_nxt;
			rx_sh_r   <= rx_sh_nxt;
			rxfs_r    <= rxfs_nxt;
			rx_pend_r <= rx_pend_nxt;
			sdo_r     <= sdo_nxt;
		end
	end

	// Converter side strobes and filter clocks
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			da_r   <= 1'b0;
			ad_r   <= 1'b0;
			tscf_r <= 1'b0;
			rscf_r <= 1'b0;
			hp_r   <= 1'b0;
		end else if (ce) begin
			da_r   <= tx_if.conv;
			ad_r   <= ad_c;
			tscf_r <= tx_if.switched_cap_filter_clock;
			rscf_r <= sync ? tx_if.switched_cap_filter_clock : rx_if.switched_cap_filter_clock;
			hp_r   <= ad_c;
		end
	end

	assign shift_clk                    = shift_r;
	assign tx_frame_sync                = txfs_r;
	assign rx_frame_sync                = rxfs_r;
	assign serial_data_from_codec       = sdo_r;
	assign dac_word                     = dac_r;
	assign da_conv_strobe               = da_r;
	assign ad_conv_strobe               = ad_r;
	assign tx_switched_cap_filter_clock = tscf_r;
	assign rx_switched_cap_filter_clock = rscf_r;
	assign hp_filter_clock              = hp_r;

	// ==================================================
	// Checks
	logic [4:0] gap_cnt_r;
	always_ff @(posedge sys_clk) begin
		if (srst) gap_cnt_r <= '0;
		else if (ce) gap_cnt_r <= (sp_r == SP_GAP) ? gap_cnt_r + BIT_ONE : '0;
	end

	ack_once_a: assert property (@(posedge sys_clk) disable iff (srst)
		(wb_ack_o && ce) |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	shift_div_a: assert property (@(posedge sys_clk) disable iff (srst)
		(!$past(srst) && !$past(srst, 2) && $past(ce) && $past(ce, 2)) |-> shift_clk != $past(shift_clk, 2))
		else $error("shift clock not master over four");
	gap_len_a: assert property (@(posedge sys_clk) disable iff (srst)
		(ce && sp_r == SP_GAP && sp_nxt == SP_SEC) |-> (gap_cnt_r == GAP_CYC_LAST && tx_frame_sync))
		else $error("secondary gap not four shift clocks");
	sec_req_a: assert property (@(posedge sys_clk) disable iff (srst)
		(ce && prim_end && word[LSB_W-1:0] == CCT_SEL_SEC) |=> (sp_r == SP_GAP && tx_frame_sync))
		else $error("low bits 11 did not request a secondary");
	trim_plus_a: assert property (@(posedge sys_clk) disable iff (srst)
		(ce && prim_end && word[LSB_W-1:0] == CCT_SEL_PLUS) |=> (tx_sel_r == CCT_SEL_PLUS && rx_sel_r == CCT_SEL_PLUS))
		else $error("low bits 01 did not select base plus trim");
	trim_minus_a: assert property (@(posedge sys_clk) disable iff (srst)
		(ce && prim_end && word[LSB_W-1:0] == CCT_SEL_MINUS) |=> tx_sel_r == CCT_SEL_MINUS)
		else $error("low bits 10 did not select base minus trim");
	sync_rx_a: assert property (@(posedge sys_clk) disable iff (srst)
		(sync && sp_r == SP_SEC) |-> rx_frame_sync)
		else $error("receive frame sync during secondary in sync mode");
	sync_conv_a: assert property (@(posedge sys_clk) disable iff (srst)
		($past(ce) && $past(sync) && sync) |-> ad_conv_strobe == da_conv_strobe)
		else $error("A/D timing not taken from transmit pair");

endmodule : cct_timing
